// ---- inc/adc_pkg.sv ----
// constants, register map and types for the converter control block
// assumes a single 100 MHz clock standing for the oscillator period
`default_nettype none
package adc_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TCY_OSC       = 4;
   localparam int TCY_CLKS      = TCY_OSC;
   localparam int RC_TAD_NS     = 4000;
   localparam int RC_TAD_CLKS   = (RC_TAD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam logic [8:0] DIV_2OSC  = 9'h002;
   localparam logic [8:0] DIV_8OSC  = 9'h008;
   localparam logic [8:0] DIV_32OSC = 9'h020;
   localparam logic [8:0] DIV_RC    = 9'(RC_TAD_CLKS);
   localparam logic [3:0] CONV_TADS = 4'hc;
   localparam logic [3:0] HOLD_TADS = 4'h2;
   localparam logic [3:0] RES_BITS  = 4'ha;
   localparam logic [2:0] TCY_CNT   = 3'(TCY_CLKS);
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [2:0] REG_CTRL  = 3'h0;
   localparam logic [2:0] REG_CFG   = 3'h1;
   localparam logic [2:0] REG_RESH  = 3'h2;
   localparam logic [2:0] REG_RESL  = 3'h3;
   localparam logic [2:0] REG_STAT  = 3'h4;
   localparam logic [2:0] REG_PORT  = 3'h5;
   localparam int CTRL_CLK_HI = 7;
   localparam int CTRL_CLK_LO = 6;
   localparam int CTRL_CHS_HI = 5;
   localparam int CTRL_CHS_LO = 3;
   localparam int CTRL_GO     = 2;
   localparam int CTRL_ON     = 0;
   localparam int CFG_FMT     = 7;
   localparam int STAT_DONE   = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] CLK_SEL_RC = 2'b11;
   localparam logic [1:0] CLK_SEL_2  = 2'b00;
   localparam logic [1:0] CLK_SEL_8  = 2'b01;
   // analog-pin masks per port configuration code, bit n = channel n
   localparam logic [7:0] ANALOG_MASK [16] = '{
      8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
      8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'b0001,
      ST_FIRST = 4'b0010,
      ST_CONV  = 4'b0100,
      ST_HOLD  = 4'b1000
   } adc_state_t;
endpackage : adc_pkg
`default_nettype wire

// ---- inc/adc_sar_if.sv ----
// link between the control logic and the approximation core
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface adc_sar_if;
   logic        start;
   logic        bit_en;
   logic [15:0] sample;
   logic [9:0]  code;
   logic        done;
   modport ctrl (output start, output bit_en, output sample,
                 input code, input done);
   modport core (input start, input bit_en, input sample,
                 output code, output done);
endinterface : adc_sar_if
`default_nettype wire

// ---- src/adc_tad_div.sv ----
// bit-period divider: one-cycle tick per conversion bit period
// assumes the clock is the oscillator period
`timescale 1ns/1ps
`default_nettype none
module adc_tad_div
   import adc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       run,
   input  wire logic       clr,
   input  wire logic [1:0] sel,
   output var  logic       tick
);
   logic [8:0] cnt_r;
   logic [8:0] lim;

   always_comb
   begin
      unique case (sel)
         CLK_SEL_2:  lim = DIV_2OSC;
         CLK_SEL_8:  lim = DIV_8OSC;
         CLK_SEL_RC: lim = DIV_RC;
         default:    lim = DIV_32OSC;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !run || clr)
      begin
         cnt_r <= 9'h000;
         tick  <= 1'b0;
      end
      else if (cnt_r == lim - 9'h001)
      begin
         cnt_r <= 9'h000;
         tick  <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 9'h001;
         tick  <= 1'b0;
      end
   end
endmodule : adc_tad_div
`default_nettype wire

// ---- src/adc_sar_core.sv ----
// successive-approximation core: ten trials, msb first
// assumes sample is a 16-bit fraction of the reference span
`timescale 1ns/1ps
`default_nettype none
module adc_sar_core
   import adc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   adc_sar_if.core   sar
);
   logic [15:0] samp_r;
   logic [9:0]  code_r;
   logic [3:0]  idx_r;
   logic        busy_r;
   logic        done_r;
   logic [9:0]  trial;

   assign trial    = code_r | 10'(10'h001 << idx_r);
   assign sar.code = code_r;
   assign sar.done = done_r;

   always_ff @(posedge sys_clk)
   begin
      done_r <= 1'b0;
      if (sys_rst)
      begin
         busy_r <= 1'b0;
         code_r <= 10'h000;
         idx_r  <= 4'h0;
         samp_r <= 16'h0000;
      end
      else if (sar.start)
      begin
         samp_r <= sar.sample;
         code_r <= 10'h000;
         idx_r  <= RES_BITS - 4'h1;
         busy_r <= 1'b1;
      end
      else if (busy_r && sar.bit_en)
      begin
         // code k whenever input >= k/1024 of span
         if ({trial, 6'h00} <= samp_r)
            code_r <= trial;
         if (idx_r == 4'h0)
         begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end
         else
            idx_r <= idx_r - 4'h1;
      end
   end
endmodule : adc_sar_core
`default_nettype wire

// ---- src/adc_conv_ctrl.sv ----
// converter control: registers, sequencing, sleep and result logic
// assumes the core drives the register port one strobe at a time
//
// Function
// - channel and direction never gate sequencing
// - analog-configured pins read zero in port
// - digital-configured pins still convert normally
// - clearing start aborts, result kept
// - after abort wait two bit periods, reacquire
// - first segment one instruction cycle up to one period
// - load ten-bit result justified by format bit
// - unused result bits loaded with zeros
// - result bytes writable as plain registers
// - sleep conversion only with internal rc clock
// - rc clock waits one instruction cycle first
// - sleep completion clears start, loads, wakes if done_int_en set
// - sleep done without interrupt powers down
// - sleep with other clocks aborts, powers down
// - reset clears control, aborts conversion
// - reset leaves result pair untouched
// - first code step at 1/1024 span
// - completion loads result, clears start, sets flag
// - conversion lasts twelve bit periods
// - right justify zero high six, left zero low six
// - clock select 2, 8, 32 osc, or rc
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl
   import adc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [2:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output var  logic [7:0]   reg_rdata,
   input  wire logic [7:0]   pin_direction_bits,
   input  wire logic [7:0]   pin_out,
   input  wire logic [7:0]   pin_level,
   input  wire logic [127:0] analog_input_pins,
   input  wire logic         sleep_mode,
   input  wire logic         done_int_en,
   output var  logic         conversion_done_flag,
   output var  logic         wake_req,
   output var  logic         conv_powered,
   output var  logic         acquiring
);
   import adc_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   adc_state_t  state_r;
   adc_state_t  state_nxt;
   logic [1:0]  conv_clock_select_r;
   logic [2:0]  channel_select_r;
   logic        go_r;
   logic        converter_on_bit_r;
   logic        result_format_bit_r;
   logic [3:0]  pcfg_r;
   logic [7:0]  result_high_byte_r;
   logic [7:0]  result_low_byte_r;
   logic        pdown_r;
   logic        sleep_q_r;
   logic [3:0]  tad_cnt_r;
   logic [2:0]  cyc_cnt_r;
   logic [9:0]  code_hold_r;
   logic        done_r;
   logic        wake_r;
   logic        powered_r;
   logic        acq_r;
   logic [7:0]  rdata_r;
   logic        tick;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        busy;
   logic        ready;
   logic        start;
   logic        sw_abort;
   logic        off_abort;
   logic        sleep_rise;
   logic        sleep_pd;
   logic        sleep_abort;
   logic        abort_any;
   logic        first_end;
   logic        conv_end;
   logic        hold_end;
   logic        is_rc;
   logic [15:0] chan_sample;
   logic [7:0]  rd_mux;
   logic [9:0]  code_now;

   adc_sar_if sar ();

   // ************************************************************
   // decode
   // ************************************************************
   assign wr_ctrl    = reg_wr && (reg_addr == REG_CTRL);
   assign wr_stat    = reg_wr && (reg_addr == REG_STAT);
   assign busy       = (state_r == ST_FIRST) || (state_r == ST_CONV);
   assign ready      = converter_on_bit_r && !pdown_r;
   assign is_rc      = (conv_clock_select_r == CLK_SEL_RC);
   // old on bit gates start: a write that powers up cannot also start
   assign start      = wr_ctrl && reg_wdata[CTRL_GO] && ready
                       && (state_r == ST_IDLE);
   assign sw_abort   = wr_ctrl && !reg_wdata[CTRL_GO] && busy;
   assign off_abort  = wr_ctrl && !reg_wdata[CTRL_ON];
   assign sleep_rise = sleep_mode && !sleep_q_r;
   assign sleep_pd   = sleep_rise && !is_rc && converter_on_bit_r;
   assign sleep_abort = sleep_pd && busy;
   assign abort_any  = sw_abort || sleep_abort;
   // rc start waits a full instruction cycle so sleep can follow
   assign first_end  = (state_r == ST_FIRST) && tick
                       && (cyc_cnt_r == TCY_CNT);
   assign conv_end   = (state_r == ST_CONV) && tick
                       && (tad_cnt_r == CONV_TADS - 4'h1);
   assign hold_end   = (state_r == ST_HOLD) && tick
                       && (tad_cnt_r == HOLD_TADS - 4'h1);

   // ************************************************************
   // bit-period divider and approximation core
   // ************************************************************
   adc_tad_div u_div
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (state_r != ST_IDLE),
      .clr     (start || abort_any),
      .sel     (conv_clock_select_r),
      .tick    (tick)
   );

   adc_sar_core u_core
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .sar     (sar.core)
   );

   // direction output feeds the driven level into the path
   always_comb
   begin
      if (pin_direction_bits[channel_select_r])
         chan_sample = analog_input_pins[16*channel_select_r +: 16];
      else
         chan_sample = {16{pin_out[channel_select_r]}};
   end

   // port configuration is not consulted: digital pins convert too
   assign sar.sample = chan_sample;
   assign sar.start  = first_end;
   assign sar.bit_en = (state_r == ST_CONV) && tick;
   assign code_now   = sar.done ? sar.code : code_hold_r;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         code_hold_r <= 10'h000;
      else if (sar.done)
         code_hold_r <= sar.code;
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (start)
               state_nxt = ST_FIRST;
         end
         ST_FIRST:
         begin
            if (off_abort)
               state_nxt = ST_IDLE;
            else if (abort_any)
               state_nxt = ST_HOLD;
            else if (first_end)
               state_nxt = ST_CONV;
         end
         ST_CONV:
         begin
            if (off_abort)
               state_nxt = ST_IDLE;
            else if (abort_any || conv_end)
               state_nxt = ST_HOLD;
         end
         ST_HOLD:
         begin
            if (off_abort || hold_end)
               state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_nxt != state_r)
         tad_cnt_r <= 4'h0;
      else if (tick)
         tad_cnt_r <= tad_cnt_r + 4'h1;
   end

   // counts oscillator periods toward the first instruction cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_r != ST_FIRST)
         cyc_cnt_r <= 3'h1;
      else if (cyc_cnt_r != TCY_CNT)
         cyc_cnt_r <= cyc_cnt_r + 3'h1;
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         conv_clock_select_r <= CTRL_RST[CTRL_CLK_HI:CTRL_CLK_LO];
         channel_select_r    <= CTRL_RST[CTRL_CHS_HI:CTRL_CHS_LO];
         converter_on_bit_r  <= CTRL_RST[CTRL_ON];
      end
      else if (wr_ctrl)
      begin
         conv_clock_select_r <= reg_wdata[CTRL_CLK_HI:CTRL_CLK_LO];
         channel_select_r    <= reg_wdata[CTRL_CHS_HI:CTRL_CHS_LO];
         converter_on_bit_r  <= reg_wdata[CTRL_ON];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         go_r <= CTRL_RST[CTRL_GO];
      else if (conv_end || sleep_abort || off_abort)
         go_r <= 1'b0;
      else if (start)
         go_r <= 1'b1;
      else if (wr_ctrl && !reg_wdata[CTRL_GO])
         go_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         result_format_bit_r <= 1'b0;
         pcfg_r              <= 4'h0;
      end
      else if (reg_wr && reg_addr == REG_CFG)
      begin
         result_format_bit_r <= reg_wdata[CFG_FMT];
         pcfg_r              <= reg_wdata[3:0];
      end
   end

   // ************************************************************
   // sleep and power
   // ************************************************************
   // on bit keeps reading set while the analog part is down
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pdown_r   <= 1'b0;
         sleep_q_r <= 1'b0;
      end
      else
      begin
         sleep_q_r <= sleep_mode;
         if (sleep_pd)
            pdown_r <= 1'b1;
         else if (conv_end && sleep_mode && !done_int_en)
            pdown_r <= 1'b1;
         else if (!sleep_mode || (wr_ctrl && !reg_wdata[CTRL_ON]))
            pdown_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wake_r    <= 1'b0;
         powered_r <= 1'b0;
         acq_r     <= 1'b0;
      end
      else
      begin
         wake_r    <= conv_end && sleep_mode && done_int_en;
         powered_r <= ready;
         acq_r     <= ready && (state_r == ST_IDLE);
      end
   end

   // ************************************************************
   // result pair
   // ************************************************************
   // no reset: the pair survives resets and powers up unknown
   always_ff @(posedge sys_clk)
   begin
      if (conv_end)
      begin
         if (result_format_bit_r)
         begin
            result_high_byte_r <= {6'h00, code_now[9:8]};
            result_low_byte_r  <= code_now[7:0];
         end
         else
         begin
            result_high_byte_r <= code_now[9:2];
            result_low_byte_r  <= {code_now[1:0], 6'h00};
         end
      end
      else if (reg_wr && reg_addr == REG_RESH)
         result_high_byte_r <= reg_wdata;
      else if (reg_wr && reg_addr == REG_RESL)
         result_low_byte_r <= reg_wdata;
   end

   // hardware set beats a software clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         done_r <= 1'b0;
      else if (conv_end)
         done_r <= 1'b1;
      else if (wr_stat && !reg_wdata[STAT_DONE])
         done_r <= 1'b0;
   end

   // ************************************************************
   // read port
   // ************************************************************
   always_comb
   begin
      unique case (reg_addr)
         REG_CTRL: rd_mux = {conv_clock_select_r, channel_select_r,
                             go_r, 1'b0, converter_on_bit_r};
         REG_CFG:  rd_mux = {result_format_bit_r, 3'h0, pcfg_r};
         REG_RESH: rd_mux = result_high_byte_r;
         REG_RESL: rd_mux = result_low_byte_r;
         REG_STAT: rd_mux = {5'h00, acq_r, powered_r, done_r};
         REG_PORT: rd_mux = pin_level & ~ANALOG_MASK[pcfg_r];
         default:  rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !reg_rd)
         rdata_r <= 8'h00;
      else
         rdata_r <= rd_mux;
   end

   assign reg_rdata            = rdata_r;
   assign conversion_done_flag = done_r;
   assign wake_req             = wake_r;
   assign conv_powered         = powered_r;
   assign acquiring            = acq_r;
endmodule : adc_conv_ctrl
`default_nettype wire

// ---- dv/adc_conv_ctrl_checker.sv ----
// checker for adc_conv_ctrl, bound to every instance of it
// assumes the register map and timing constants of adc_pkg
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl_checker
   import adc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic [7:0] pin_level,
   input  wire logic       sleep_mode,
   input  wire logic       done_int_en,
   input  wire logic       conversion_done_flag,
   input  wire logic       wake_req,
   input  wire logic       conv_powered,
   input  wire logic       acquiring
);
   // ********
   // shadow of software-written fields
   // ********
   logic [1:0] clksel_r;
   logic [3:0] pcfg_r;
   logic       on_r;
   logic       resh_ok_r;
   logic [7:0] resh_w_r;
   default clocking cb @(posedge sys_clk);
   endclocking
   always_ff @(posedge sys_clk)
      if (sys_rst)
      begin
         clksel_r  <= 2'b00;
         on_r      <= 1'b0;
         pcfg_r    <= 4'h0;
         resh_ok_r <= 1'b0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == REG_CTRL)
         begin
            clksel_r <= reg_wdata[CTRL_CLK_HI:CTRL_CLK_LO];
            on_r     <= reg_wdata[CTRL_ON];
         end
         if (reg_addr == REG_CFG)
            pcfg_r <= reg_wdata[3:0];
         // a result can only land while the converter is on
         if (reg_addr == REG_RESH)
            resh_ok_r <= !on_r;
         if (reg_addr == REG_CTRL && reg_wdata[CTRL_ON])
            resh_ok_r <= 1'b0;
      end
   always_ff @(posedge sys_clk)
      if (reg_wr && reg_addr == REG_RESH)
         resh_w_r <= reg_wdata;
   // ********
   // sequences and assertions
   // ********
   sequence s_fast_start;
      reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO]
         && reg_wdata[CTRL_CLK_HI:CTRL_CLK_LO] == CLK_SEL_2
         && acquiring && !sleep_mode;
   endsequence
   sequence s_busy_span;
      ##2 !acquiring ##25 !acquiring;
   endsequence
   a_reset_clears: assert property (
      sys_rst |=> !conv_powered && !acquiring && !conversion_done_flag
         && !wake_req)
      else $error("outputs not cleared by reset");
   a_conv_length: assert property (disable iff (sys_rst)
      s_fast_start |-> s_busy_span ##[1:20] acquiring)
      else $error("conversion span wrong");
   a_hold_after: assert property (disable iff (sys_rst)
      $rose(conversion_done_flag) |-> (!acquiring)[*3])
      else $error("acquisition resumed without hold");
   a_sleep_abort: assert property (disable iff (sys_rst)
      $rose(sleep_mode) && clksel_r != CLK_SEL_RC |-> ##[1:2] !conv_powered)
      else $error("sleep did not power down");
   a_sleep_rc_off: assert property (disable iff (sys_rst)
      $rose(conversion_done_flag) && sleep_mode && !done_int_en
         |-> ##[0:2] !conv_powered)
      else $error("no power down after sleep conversion");
   a_wake_pulse: assert property (disable iff (sys_rst)
      wake_req |-> $past(sleep_mode) && $past(done_int_en) ##1 !wake_req)
      else $error("wake without cause or too long");
   a_port_masked: assert property (disable iff (sys_rst)
      reg_rd && reg_addr == REG_PORT
         |=> reg_rdata == $past(pin_level & ~ANALOG_MASK[pcfg_r]))
      else $error("analog pin not read as zero");
   a_result_plain: assert property (disable iff (sys_rst)
      reg_rd && reg_addr == REG_RESH && resh_ok_r |=> reg_rdata == resh_w_r)
      else $error("result byte lost written value");
endmodule : adc_conv_ctrl_checker
bind adc_conv_ctrl adc_conv_ctrl_checker u_adc_conv_ctrl_checker (.*);
`default_nettype wire

// ---- dv/adc_core_model.sv ----
// processor core model: register master, pins and sleep control
// assumes the adc_conv_ctrl register port on one clock
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
   import adc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic [7:0]   reg_rdata,
   output var  logic [2:0]   reg_addr,
   output var  logic [7:0]   reg_wdata,
   output var  logic         reg_wr,
   output var  logic         reg_rd,
   output var  logic [7:0]   pin_direction_bits,
   output var  logic [7:0]   pin_out,
   output var  logic [7:0]   pin_level,
   output var  logic [127:0] analog_input_pins,
   output var  logic         sleep_mode,
   output var  logic         done_int_en
);
   initial
   begin
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pin_direction_bits = 8'hff;
      pin_out = 8'h0f;
      pin_level = 8'hb6;
      analog_input_pins = {64'h0, 16'habcd, 16'hffff, 16'h003f, 16'h0040};
      sleep_mode = 1'b0;
      done_int_en = 1'b0;
   end
   // idle bus shows inverted values so stale ones never look valid
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 v = reg_rdata;
   endtask : rd
   task automatic start(input logic [7:0] c, input logic slp);
      wr(REG_CTRL, c | 8'h01);
      wr(REG_CTRL, c | 8'h05);
      if (slp)
         sleep_mode <= 1'b1;
   endtask : start
   task automatic pins(input logic s, input logic ie);
      @(posedge sys_clk);
      sleep_mode  <= s;
      done_int_en <= ie;
   endtask : pins
endmodule : adc_core_model
`default_nettype wire

// ---- dv/adc_conv_ctrl_tb.sv ----
// testbench for adc_conv_ctrl driven through the core model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl_tb
   import adc_pkg::*;
;
   logic         sys_clk;
   logic         sys_rst;
   logic [2:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_rdata;
   logic [7:0]   pin_direction_bits;
   logic [7:0]   pin_out;
   logic [7:0]   pin_level;
   logic [127:0] analog_input_pins;
   logic         sleep_mode;
   logic         done_int_en;
   logic         conversion_done_flag;
   logic         wake_req;
   logic         conv_powered;
   logic         acquiring;
   int           fails;
   int           total_checks;
   int           n;
   logic         woke;
   logic [7:0]   d;
   int           tads [4] = '{2, 8, 32, RC_TAD_CLKS};
   logic [7:0]   cfgs [4] = '{8'h00, 8'h80, 8'h06, 8'h80};
   initial
      sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   adc_conv_ctrl u_adc_conv_ctrl (.*);
   adc_core_model u_adc_core_model (.*);
   // ********
   // checking and waiting
   // ********
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input int g);
      total_checks++;
      if (g < lo || g > hi)
      begin
         fails++;
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask : chk_rng
   task automatic tick(input int k);
      repeat (k)
      begin
         @(posedge sys_clk);
         #1;
         if (wake_req === 1'b1)
            woke = 1'b1;
      end
   endtask : tick
   // bounded: a stuck sequencer ends the run instead of hanging it
   task automatic wait_for(input logic acq, input int lim);
      n = 0;
      while ((acq ? acquiring : conversion_done_flag) !== 1'b1 && n < lim)
      begin
         tick(1);
         n++;
      end
      if (n >= lim)
      begin
         fails++;
         $display("BAD wait exp %0d got timeout", lim);
         finish_test();
      end
   endtask : wait_for
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      u_adc_core_model.wr(a, v);
   endtask : wr
   task automatic rd_chk(input string nm, input logic [2:0] a,
                         input logic [7:0] e);
      u_adc_core_model.rd(a, d);
      chk8(nm, e, d);
   endtask : rd_chk
   task automatic run_conv(input logic [7:0] c, input logic [7:0] cfg,
                           input logic slp);
      logic [9:0]  code;
      logic [15:0] res;
      int          tad;
      code = analog_input_pins[16 * c[5:3] + 6 +: 10];
      res = cfg[7] ? {6'h00, code} : {code, 6'h00};
      tad = tads[c[7:6]];
      wr(REG_CFG, cfg);
      wr(REG_STAT, 8'h00);
      u_adc_core_model.start(c, slp);
      wait_for(1'b0, 6000);
      chk_rng("conv_time", 12 * tad, 13 * tad + 16, n);
      rd_chk("res_high", REG_RESH, res[15:8]);
      rd_chk("res_low", REG_RESL, res[7:0]);
      rd_chk("ctrl_done", REG_CTRL, c | 8'h01);
   endtask : run_conv
   // ********
   // main sequence
   // ********
   initial
   begin
      sys_rst = 1'b1;
      woke = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk("ctrl_rst", REG_CTRL, 8'h00);
      rd_chk("stat_rst", REG_STAT, 8'h00);
      wr(REG_RESH, 8'h5a);
      rd_chk("resh_plain", REG_RESH, 8'h5a);
      wr(REG_RESL, 8'ha5);
      rd_chk("resl_plain", REG_RESL, 8'ha5);
      wr(3'h7, 8'hff);
      rd_chk("unmapped", 3'h7, 8'h00);
      for (int k = 0; k < 16; k++)
      begin
         wr(REG_CFG, 8'(k));
         rd_chk("port", REG_PORT, pin_level & ~ANALOG_MASK[k]);
      end
      // digital-configured channel 2 must still convert
      for (int i = 0; i < 4; i++)
      begin
         run_conv({2'(i), 3'(i), 3'h0}, cfgs[i], 1'b0);
         wait_for(1'b1, 1000);
      end
      u_adc_core_model.start(8'h50, 1'b0);
      tick(20);
      wr(REG_CTRL, 8'h51);
      wait_for(1'b1, 1000);
      chk_rng("abort_hold", 16, 24, n);
      rd_chk("abort_resh", REG_RESH, 8'h02);
      rd_chk("abort_resl", REG_RESL, 8'haf);
      u_adc_core_model.start(8'h40, 1'b1);
      tick(6);
      chk8("slp_power", 8'h00, {7'h0, conv_powered});
      rd_chk("slp_ctrl", REG_CTRL, 8'h41);
      rd_chk("slp_resh", REG_RESH, 8'h02);
      u_adc_core_model.pins(1'b0, 1'b1);
      wait_for(1'b1, 1000);
      woke = 1'b0;
      run_conv(8'hd0, 8'h00, 1'b1);
      tick(2);
      chk8("woke", 8'h01, {7'h0, woke});
      u_adc_core_model.pins(1'b0, 1'b0);
      wait_for(1'b1, 1000);
      woke = 1'b0;
      run_conv(8'hc0, 8'h80, 1'b1);
      tick(3);
      chk8("rc_power", 8'h00, {7'h0, conv_powered});
      chk8("no_wake", 8'h00, {7'h0, woke});
      u_adc_core_model.pins(1'b0, 1'b0);
      wait_for(1'b1, 1000);
      u_adc_core_model.start(8'h48, 1'b0);
      tick(10);
      @(posedge sys_clk) sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk("rst_ctrl", REG_CTRL, 8'h00);
      rd_chk("rst_stat", REG_STAT, 8'h00);
      rd_chk("rst_resh", REG_RESH, 8'h00);
      rd_chk("rst_resl", REG_RESL, 8'h01);
      finish_test();
   end
endmodule : adc_conv_ctrl_tb
`default_nettype wire
